// [design/sfu_uart_defs.svh]
`ifndef SFU_UART_DEFS_SVH
`define SFU_UART_DEFS_SVH

// ****************************************
// register map (address is ignored by the port)
// ****************************************
`define SFU_TX_BYTE_PORT_ADDR  32'h5100_0000
`define SFU_RX_BYTE_PORT_ADDR  32'h5104_0000

// ****************************************
// frame layout and defaults
// ****************************************
`define SFU_DATA_BITS          4'h8
`define SFU_LAST_DATA_IDX      3'h7
`define SFU_LINE_IDLE          1'b1
`define SFU_START_LEVEL        1'b0
`define SFU_STOP_LEVEL         1'b1
`define SFU_CLOCK_HZ           10000000
`define SFU_BAUD               19200
`define SFU_FIFO_DEPTH         16
`define SFU_RDATA_PAD          8'h00

`endif

// [design/sfu_uart_pkg.sv]
package sfu_uart_pkg;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } sfu_apb_req_type;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA  = 4'b0100,
      TX_STOP  = 4'b1000
   } sfu_tx_state_type;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } sfu_rx_state_type;

endpackage : sfu_uart_pkg

// [design/sfu_serial_port_block.sv]
`timescale 1ns/10ps
`include "sfu_uart_defs.svh"
// Function
// - frame is start, eight data, one stop
// - no flow control lines at all
// - baud is a parameter, default 19200
// - tick counter wraps at computed maximum
// - separate transmit and receive FIFOs
// - every write pushes transmit FIFO
// - only write data bits 7:0 used
// - write to full FIFO silently dropped
// - transmitter sends whenever FIFO holds data
// - receive sampled once per bit, stored
// - every read of a non-empty FIFO pops receive FIFO
// - read data upper byte always zero
// - read of empty FIFO is undefined
// - interrupt high while receive data pending
module sfu_serial_port_block #(
   parameter int clock_frequency_param = `SFU_CLOCK_HZ,
   parameter int target_baud_param     = `SFU_BAUD,
   parameter int FIFO_DEPTH            = `SFU_FIFO_DEPTH
) (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          clkEn,
   input  wire sfu_uart_pkg::sfu_apb_req_type apbReq,
   output logic [15:0]                        apbRdata,
   output logic                               transferDoneOut,
   input  wire logic                          serialInLine,
   output logic                               serialOutLine,
   output logic                               rxIrq
);

   // ****************************************
   // bit-rate tick
   // ****************************************
   localparam int TICK_MAX = clock_frequency_param / target_baud_param - 1;
   localparam int CW = $clog2(TICK_MAX + 2);
   localparam int AW = $clog2(FIFO_DEPTH);

   logic [CW-1:0] txCnt_q;
   logic [CW-1:0] rxCnt_q;
   wire           txTick = (txCnt_q == CW'(TICK_MAX));
   wire           rxTick = (rxCnt_q == CW'(TICK_MAX));

   // ****************************************
   // APB slave, no wait states
   // ****************************************
   wire apbAccess = apbReq.sel & apbReq.enable;
   wire apbWr     = apbAccess & apbReq.write;
   wire apbRd     = apbAccess & ~apbReq.write;
   assign transferDoneOut = 1'b1;

   // ****************************************
   // FIFOs
   // ****************************************
   logic [7:0]  txMem [FIFO_DEPTH];
   logic [7:0]  rxMem [FIFO_DEPTH];
   logic [AW:0] txWp_q, txRp_q, rxWp_q, rxRp_q;

   wire txEmpty = (txWp_q == txRp_q);
   wire txFull  = (txWp_q[AW-1:0] == txRp_q[AW-1:0]) & (txWp_q[AW] != txRp_q[AW]);
   wire rxEmpty = (rxWp_q == rxRp_q);
   wire rxFull  = (rxWp_q[AW-1:0] == rxRp_q[AW-1:0]) & (rxWp_q[AW] != rxRp_q[AW]);
   wire txPush  = apbWr & ~txFull; // no flag, byte just lost
   wire rxPop   = apbRd & ~rxEmpty;

   assign rxIrq = ~rxEmpty;

   // ****************************************
   // transmitter
   // ****************************************
   sfu_uart_pkg::sfu_tx_state_type txState_q;
   logic [7:0] txShift_q;
   logic [2:0] txIdx_q;
   logic       txLine_q;
   wire        txPop = (txState_q == sfu_uart_pkg::TX_IDLE) & ~txEmpty;

   // ****************************************
   // receiver
   // ****************************************
   sfu_uart_pkg::sfu_rx_state_type rxState_q;
   logic [7:0] rxShift_q;
   logic [2:0] rxIdx_q;
   logic [2:0] rxSync_q;
   logic       rxLevel_q;
   logic       rxPush_q;
   // change accepted only when stages two and three agree
   wire        rxSyncAgree = (rxSync_q[1] == rxSync_q[2]);

   // ****************************************
   // receive pin synchroniser
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxSync_q <= 3'b111;
      end else if (clkEn) begin
         rxSync_q <= {rxSync_q[1:0], serialInLine};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxLevel_q <= `SFU_LINE_IDLE;
      end else if (clkEn && rxSyncAgree) begin
         rxLevel_q <= rxSync_q[2];
      end
   end

   // ****************************************
   // fifo storage
   // ****************************************
   // no reset on storage: empty reads return stale bytes
   always_ff @(posedge clk) begin
      if (clkEn && txPush) begin
         txMem[txWp_q[AW-1:0]] <= apbReq.wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (clkEn && rxPush_q) begin
         rxMem[rxWp_q[AW-1:0]] <= rxShift_q;
      end
   end

   // ****************************************
   // fifo pointers
   // ****************************************
   wire [AW:0] txWp_d = txWp_q + 1'b1;
   wire [AW:0] txRp_d = txRp_q + 1'b1;
   wire [AW:0] rxWp_d = rxWp_q + 1'b1;
   wire [AW:0] rxRp_d = rxRp_q + 1'b1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txWp_q <= '0;
      end else if (clkEn && txPush) begin
         txWp_q <= txWp_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txRp_q <= '0;
      end else if (clkEn && txPop) begin
         txRp_q <= txRp_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxWp_q <= '0;
      end else if (clkEn && rxPush_q) begin
         rxWp_q <= rxWp_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxRp_q <= '0;
      end else if (clkEn && rxPop) begin
         rxRp_q <= rxRp_d;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   // data valid only while rxIrq was high
   wire [15:0] apbRdata_d = {`SFU_RDATA_PAD, rxMem[rxRp_q[AW-1:0]]};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         apbRdata <= 16'h0000;
      end else if (clkEn && apbRd) begin
         apbRdata <= apbRdata_d;
      end
   end

   // ****************************************
   // transmit bit-rate counter
   // ****************************************
   // held at zero while idle so every start bit is a full period
   wire [CW-1:0] txCnt_d = (txTick || txState_q == sfu_uart_pkg::TX_IDLE) ? '0 : txCnt_q + 1'b1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txCnt_q <= '0;
      end else if (clkEn) begin
         txCnt_q <= txCnt_d;
      end
   end

   // ****************************************
   // transmit sequencer
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txState_q <= sfu_uart_pkg::TX_IDLE;
         txShift_q <= 8'h00;
         txIdx_q   <= 3'h0;
         txLine_q  <= `SFU_LINE_IDLE;
      end else if (clkEn) begin
         case (txState_q)
            sfu_uart_pkg::TX_IDLE: begin
               txLine_q <= `SFU_LINE_IDLE;
               if (txPop) begin
                  txShift_q <= txMem[txRp_q[AW-1:0]];
                  txLine_q  <= `SFU_START_LEVEL;
                  txState_q <= sfu_uart_pkg::TX_START;
               end
            end
            sfu_uart_pkg::TX_START: begin
               if (txTick) begin
                  txLine_q  <= txShift_q[0];
                  txIdx_q   <= 3'h0;
                  txState_q <= sfu_uart_pkg::TX_DATA;
               end
            end
            sfu_uart_pkg::TX_DATA: begin
               if (txTick) begin
                  if (txIdx_q == `SFU_LAST_DATA_IDX) begin
                     txLine_q  <= `SFU_STOP_LEVEL;
                     txState_q <= sfu_uart_pkg::TX_STOP;
                  end else begin
                     txLine_q  <= txShift_q[txIdx_q + 3'h1];
                     txIdx_q   <= txIdx_q + 3'h1;
                  end
               end
            end
            sfu_uart_pkg::TX_STOP: begin
               if (txTick) begin
                  txLine_q  <= `SFU_LINE_IDLE;
                  txState_q <= sfu_uart_pkg::TX_IDLE;
               end
            end
            default: begin
               txState_q <= sfu_uart_pkg::TX_IDLE;
            end
         endcase
      end
   end

   assign serialOutLine = txLine_q; // no handshake gating

   // ****************************************
   // receive sequencer
   // ****************************************
   // one sample per bit, no oversampling: mid-bit point found only
   // by the half-period wait after the start edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxState_q <= sfu_uart_pkg::RX_IDLE;
         rxShift_q <= 8'h00;
         rxIdx_q   <= 3'h0;
         rxCnt_q   <= '0;
         rxPush_q  <= 1'b0;
      end else if (clkEn) begin
         rxPush_q <= 1'b0;
         rxCnt_q <= rxTick ? '0 : rxCnt_q + 1'b1;
         case (rxState_q)
            sfu_uart_pkg::RX_IDLE: begin
               if (rxLevel_q == `SFU_START_LEVEL) begin
                  rxCnt_q   <= CW'(TICK_MAX / 2);
                  rxState_q <= sfu_uart_pkg::RX_START;
               end
            end
            sfu_uart_pkg::RX_START: begin
               if (rxTick) begin
                  rxIdx_q   <= 3'h0;
                  rxState_q <= (rxLevel_q == `SFU_START_LEVEL) ?
                               sfu_uart_pkg::RX_DATA : sfu_uart_pkg::RX_IDLE;
               end
            end
            sfu_uart_pkg::RX_DATA: begin
               if (rxTick) begin
                  rxShift_q <= {rxLevel_q, rxShift_q[7:1]};
                  rxIdx_q   <= rxIdx_q + 3'h1;
                  if (rxIdx_q == `SFU_LAST_DATA_IDX) begin
                     rxState_q <= sfu_uart_pkg::RX_STOP;
                  end
               end
            end
            sfu_uart_pkg::RX_STOP: begin
               if (rxTick) begin
                  // bad stop bit discards the byte; full fifo drops it
                  rxPush_q  <= (rxLevel_q == `SFU_STOP_LEVEL) & ~rxFull;
                  rxState_q <= sfu_uart_pkg::RX_IDLE;
               end
            end
            default: begin
               rxState_q <= sfu_uart_pkg::RX_IDLE;
            end
         endcase
      end
   end

endmodule : sfu_serial_port_block

// [tb/sfu_serial_port_block_chk.sv]
`timescale 1ns/10ps
module sfu_serial_port_block_chk (
   input wire logic                          clk,
   input wire logic                          arst_n,
   input wire logic                          clkEn,
   input wire sfu_uart_pkg::sfu_apb_req_type apbReq,
   input wire logic [15:0]                   apbRdata,
   input wire logic                          transferDoneOut,
   input wire logic                          serialInLine,
   input wire logic                          serialOutLine,
   input wire logic                          rxIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire rdAcc = clkEn & apbReq.sel & apbReq.enable & ~apbReq.write;
   // ****************************************
   // checks (counts assume 10 clk per bit)
   // ****************************************
   done_high_a: assert property (transferDoneOut) else $error("ready low");
   rdata_pad_a: assert property (apbRdata[15:8] == 8'h00) else $error("pad");
   start_len_a: assert property ($fell(serialOutLine) |-> !serialOutLine [*8] ##1 !serialOutLine)
      else $error("short start bit");
   bit_len_a: assert property ($changed(serialOutLine) |=> $stable(serialOutLine) [*8])
      else $error("short bit");
   idle_out_a: assert property ($rose(arst_n) |-> serialOutLine && !rxIrq)
      else $error("not idle after reset");
   rdata_hold_a: assert property (!rdAcc |=> $stable(apbRdata))
      else $error("read data moved");
   irq_hold_a: assert property (rxIrq && !rdAcc |=> rxIrq)
      else $error("irq dropped");
   freeze_hold_a: assert property (!clkEn |=> $stable(serialOutLine) && $stable(rxIrq))
      else $error("moved while frozen");
   cover property (rdAcc && rxIrq);
   cover property ($fell(serialOutLine));
   cover property ($fell(rxIrq));
endmodule : sfu_serial_port_block_chk

// [tb/sfu_serial_partner.sv]
`timescale 1ns/10ps
module sfu_serial_partner #(
   parameter int BIT = 10
) (
   input wire logic        clk,
   input wire logic        fromDut,
   output logic            toDut,
   output logic [7:0]      gotByte,
   output int              gotCount
);
   initial begin
      toDut = 1'b1;
      gotCount = 0;
   end
   // ****************************************
   // receive: mid-bit sampling, lsb first
   // ****************************************
   always begin
      @(negedge fromDut);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         gotByte[i] = fromDut;
      end
      repeat (BIT) @(posedge clk);
      if (fromDut) gotCount++;
   end
   // bad stop lets the bench check frame rejection; no handshake lines exist
   task send(input logic [7:0] b, input logic bad);
      logic [9:0] f;
      f = {~bad, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         toDut <= f[i];
         repeat (BIT) @(posedge clk);
      end
      toDut <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask : send
endmodule : sfu_serial_partner

// [tb/test_sfu_serial_port_block.sv]
`timescale 1ns/10ps
module test_sfu_serial_port_block;
   logic                          clk, arst_n, clkEn, serialInLine, serialOutLine;
   logic                          rxIrq, transferDoneOut;
   logic [15:0]                   apbRdata, rd;
   logic [7:0]                    gotByte;
   sfu_uart_pkg::sfu_apb_req_type apbReq;
   int                            mismatches, num_checks, cyc, c, gotCount;
   logic [15:0] rowA [3] = '{16'h0000, 16'h5104, 16'hFFFF};
   logic [15:0] rowD [3] = '{16'hA55A, 16'hFF00, 16'h12FF};
   logic [7:0]  rowE [3] = '{8'h5A, 8'h00, 8'hFF};
   sfu_serial_port_block #(.clock_frequency_param(1000000), .target_baud_param(100000),
      .FIFO_DEPTH(4)) dut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .apbReq(apbReq),
      .apbRdata(apbRdata), .transferDoneOut(transferDoneOut), .serialInLine(serialInLine),
      .serialOutLine(serialOutLine), .rxIrq(rxIrq));
   sfu_serial_partner #(.BIT(10)) partner (.clk(clk), .fromDut(serialOutLine),
      .toDut(serialInLine), .gotByte(gotByte), .gotCount(gotCount));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         close_out();
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [15:0] a, input logic [15:0] d);
      apbReq <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      apbReq.enable <= 1'b1;
      @(posedge clk);
      apbReq <= '0;
      @(posedge clk);
      rd = apbRdata;
   endtask : apb
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      clkEn = 1'b1;
      apbReq = '0;
      repeat (12) @(posedge clk);
      chk(apbRdata, 16'h0000);
      chk({15'h0000, serialOutLine}, 16'h0001);
      chk({15'h0000, rxIrq}, 16'h0000);
      chk({15'h0000, transferDoneOut}, 16'h0001);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int r = 0; r < 3; r++) begin
         c = gotCount;
         apb(1'b1, rowA[r], rowD[r]);
         for (int n = 0; n < 300 && gotCount == c; n++) @(posedge clk);
         chk({8'h00, gotByte}, {8'h00, rowE[r]});
      end
      // ****************************************
      // overflow: writes far faster than the line drains
      // ****************************************
      c = gotCount;
      repeat (7) apb(1'b1, 16'h0000, 16'h00C3);
      repeat (900) @(posedge clk);
      chk(16'(gotCount - c >= 4 && gotCount - c < 7), 16'h0001);
      // ****************************************
      // receive path, frozen read, bad stop
      // ****************************************
      partner.send(8'h3C, 1'b0);
      partner.send(8'hA1, 1'b0);
      chk({15'h0000, rxIrq}, 16'h0001);
      clkEn <= 1'b0;
      apb(1'b0, 16'h0000, 16'h0000);
      clkEn <= 1'b1;
      chk(rd, 16'h0000);
      apb(1'b0, 16'h1234, 16'h0000);
      chk(rd, 16'h003C);
      chk({15'h0000, rxIrq}, 16'h0001);
      apb(1'b0, 16'h0004, 16'h0000);
      chk(rd, 16'h00A1);
      chk({15'h0000, rxIrq}, 16'h0000);
      partner.send(8'h55, 1'b1);
      chk({15'h0000, rxIrq}, 16'h0000);
      close_out();
   end
endmodule : test_sfu_serial_port_block
bind sfu_serial_port_block sfu_serial_port_block_chk chk (.clk(clk), .arst_n(arst_n),
   .clkEn(clkEn), .apbReq(apbReq), .apbRdata(apbRdata), .transferDoneOut(transferDoneOut),
   .serialInLine(serialInLine), .serialOutLine(serialOutLine), .rxIrq(rxIrq));
